// file: shared/rwo_pkg.sv
// rwo_pkg: constants, field layouts and types of the wiper command interpreter
// assumes one 50 MHz clock and software access over an AXI4-Lite slave
// Behaviour
// - memory read uses six low data bits
// - memory write busies and refuses the interface
// - acknowledge means write cycle has finished
// - reset by command four or pin
// - reset loads last programmed memory value
// - unprogrammed memory resets wiper to midscale
// - power up midscale then restore memory
// - calibration follows the calibration disable bit
// - calibration enabled by default after reset
// - command nine with one enters shutdown
// - shutdown opens terminal A wiper switch
// - all commands still execute in shutdown
// - command nine zero or reset leaves shutdown
// - wiper code decodes to one tap
// - command five returns addressed memory word
// - wiper writes only when update allowed
// - programming only while program enable set
// - successful store sets program success bit
package rwo_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int CYC_PER_US = (1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OTP_WRITE_TIME_US = 350;
    localparam int OTP_DEPTH = 50;
    localparam int WIPER_W = 10;
    localparam int FRAME_DATA_W = 10;
    localparam logic [5:0] OTP_LOC_FIRST = 6'h01;
    localparam logic [5:0] OTP_LOC_LAST = 6'h32;

    localparam logic [3:0] CMD_NOP = 4'h0;
    localparam logic [3:0] CMD_WR_WIPER = 4'h1;
    localparam logic [3:0] CMD_RD_WIPER = 4'h2;
    localparam logic [3:0] CMD_STORE = 4'h3;
    localparam logic [3:0] CMD_SW_RESET = 4'h4;
    localparam logic [3:0] CMD_RD_OTP = 4'h5;
    localparam logic [3:0] CMD_RD_LAST = 4'h6;
    localparam logic [3:0] CMD_WR_CTRL = 4'h7;
    localparam logic [3:0] CMD_RD_CTRL = 4'h8;
    localparam logic [3:0] CMD_SHUTDOWN = 4'h9;

    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_READBACK = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int STS_BUSY = 0;
    localparam int STS_ACK = 1;
    localparam int STS_SHUTDOWN = 2;
    localparam int STS_CALIB = 3;
    localparam int STS_LAST_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic success;
        logic calibDis;
        logic updAllow;
        logic progEn;
    } rwo_ctrl_t;
    localparam rwo_ctrl_t CTRL_RESET = 4'h0;

    typedef struct packed {
        logic [1:0] spare;
        logic [3:0] cmd;
        logic [9:0] data;
    } rwo_frame_t;
    localparam logic [15:0] FRAME_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_MIDSCALE = 2'b01,
        ST_RESTORE = 2'b10
    } rwo_state_t;

    typedef enum logic [1:0] {
        SEL_CMD = 2'b00,
        SEL_READBACK = 2'b01,
        SEL_STATUS = 2'b10,
        SEL_NONE = 2'b11
    } rwo_sel_t;
endpackage

// file: design/rwo_write_timer.sv
// rwo_write_timer: length of the internal memory write cycle
// assumes start is offered only while not busy
`timescale 1ns/100ps
module rwo_write_timer #(
    parameter int CYC_PER_US = rwo_pkg::CYC_PER_US,
    parameter int WRITE_US = rwo_pkg::OTP_WRITE_TIME_US
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic start,
    output logic busy
);
    localparam int DIV_W = $clog2(CYC_PER_US + 1);
    localparam int US_W = $clog2(WRITE_US + 1);
    localparam int TOTAL = CYC_PER_US * WRITE_US;

    logic [DIV_W-1:0] div_r;
    logic [US_W-1:0] us_r;
    logic usTick;
    int busyCyc;

    // microsecond enable only runs during a write cycle
    assign usTick = busy && (div_r == DIV_W'(CYC_PER_US - 1));
    assign busy = (us_r != '0);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_r <= '0;
        end else if (!busy || usTick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            us_r <= '0;
        end else if (start && !busy) begin
            us_r <= US_W'(WRITE_US);
        end else if (usTick) begin
            us_r <= us_r - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            busyCyc <= 0;
        end else if (busy) begin
            busyCyc <= busyCyc + 1;
        end else begin
            busyCyc <= 0;
        end
    end

    busy_bound_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        busy |-> busyCyc < TOTAL) else $error("write cycle runs too long");
    busy_length_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(busy) |-> $past(busyCyc) == TOTAL - 1) else $error("write cycle too short");
endmodule // rwo_write_timer

// file: design/rwo_otp_mem.sv
// rwo_otp_mem: fifty one-time-programmable wiper locations, filled in order
// assumes writes are offered only outside a running write cycle
`timescale 1ns/100ps
module rwo_otp_mem #(
    parameter int WIPER_W = rwo_pkg::WIPER_W,
    parameter int DEPTH = rwo_pkg::OTP_DEPTH
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic wrEn,
    input wire logic [WIPER_W-1:0] wrData,
    input wire logic [5:0] rdAddr,
    output logic [WIPER_W-1:0] rdData,
    output logic [WIPER_W-1:0] lastData,
    output logic [5:0] lastAddr,
    output logic full
);
    logic [WIPER_W-1:0] mem_r [DEPTH];
    logic [5:0] used_r;

    function automatic logic locValid(input logic [5:0] a, input logic [5:0] used);
        return (a >= rwo_pkg::OTP_LOC_FIRST) && (a <= used);
    endfunction

    assign full = (used_r == 6'(DEPTH));
    assign lastAddr = used_r;
    // location zero is reserved, unused locations read as zero
    assign rdData = locValid(rdAddr, used_r) ? mem_r[rdAddr - 6'h01] : '0;
    assign lastData = locValid(used_r, used_r) ? mem_r[used_r - 6'h01] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_loc
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    mem_r[gi] <= '0;
                end else if (wrEn && !full && used_r == 6'(gi)) begin
                    mem_r[gi] <= wrData;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            used_r <= '0;
        end else if (wrEn && !full) begin
            used_r <= used_r + 6'h01;
        end
    end

    full_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        full |=> full && $stable(used_r)) else $error("full memory changed");
endmodule // rwo_otp_mem

// file: design/rwo_wiper_ctrl.sv
// rwo_wiper_ctrl: command interpreter of the wiper, with AXI4-Lite slave
// assumes an AXI4-Lite master with one write and one read outstanding at most
`timescale 1ns/100ps
module rwo_wiper_ctrl #(
    parameter int WIPER_W = rwo_pkg::WIPER_W,
    parameter int OTP_WRITE_US = rwo_pkg::OTP_WRITE_TIME_US
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic rstPinN,
    input wire logic [rwo_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [rwo_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [WIPER_W-1:0] wiperCode,
    output logic [(1<<WIPER_W)-1:0] tapSelect,
    output logic aSwitchClosed,
    output logic calibEnable
);
    localparam int TAPS = 1 << WIPER_W;
    localparam logic [WIPER_W-1:0] MIDSCALE = WIPER_W'(TAPS / 2);
    localparam int PAD_W = rwo_pkg::FRAME_DATA_W - WIPER_W;

    rwo_pkg::rwo_state_t state_r;
    rwo_pkg::rwo_ctrl_t ctrl_r;
    rwo_pkg::rwo_frame_t frame_r;
    rwo_pkg::rwo_frame_t frameNew;
    logic [WIPER_W-1:0] wiper_r;
    logic [15:0] readback_r;
    logic [(1<<WIPER_W)-1:0] tapSelect_r;
    logic aSwitchClosed_r;
    logic calibEnable_r;

    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic [rwo_pkg::AXI_ADDR_W-1:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;

    logic wrExec;
    logic cmdGo;
    logic busy;
    logic timerBusy;
    logic storeGo;
    logic storeOk;
    logic anyReset;
    logic [WIPER_W-1:0] otpRdData;
    logic [WIPER_W-1:0] otpLastData;
    logic [5:0] otpLastAddr;
    logic otpFull;
    logic [WIPER_W-1:0] restoreVal;
    logic [rwo_pkg::FRAME_DATA_W-1:0] wiperWord;
    logic [rwo_pkg::FRAME_DATA_W-1:0] otpWord;
    logic [31:0] statusWord;

    function automatic rwo_pkg::rwo_sel_t regSel(input logic [rwo_pkg::AXI_ADDR_W-1:0] a);
        case (a)
            rwo_pkg::ADDR_CMD: regSel = rwo_pkg::SEL_CMD;
            rwo_pkg::ADDR_READBACK: regSel = rwo_pkg::SEL_READBACK;
            rwo_pkg::ADDR_STATUS: regSel = rwo_pkg::SEL_STATUS;
            default: regSel = rwo_pkg::SEL_NONE;
        endcase
    endfunction

    // data word alignment: the 8-bit variant ignores the two lowest data bits
    function automatic logic [rwo_pkg::FRAME_DATA_W-1:0] toWord(input logic [WIPER_W-1:0] v);
        toWord = rwo_pkg::FRAME_DATA_W'({v, {rwo_pkg::FRAME_DATA_W{1'b0}}} >> WIPER_W);
    endfunction

    assign wiperCode = wiper_r;
    assign tapSelect = tapSelect_r;
    assign aSwitchClosed = aSwitchClosed_r;
    assign calibEnable = calibEnable_r;
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ---- AXI4-Lite write side: address and data taken in either order
    assign wrExec = !awready_r && !wready_r && !bvalid_r;
    assign frameNew[7:0] = wStrb_r[0] ? wData_r[7:0] : frame_r[7:0];
    assign frameNew[15:8] = wStrb_r[1] ? wData_r[15:8] : frame_r[15:8];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            awready_r <= 1'b1;
            awAddr_r <= '0;
        end else if (s_axi_awvalid && awready_r) begin
            awready_r <= 1'b0;
            awAddr_r <= s_axi_awaddr;
        end else if (bvalid_r && s_axi_bready) begin
            awready_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wready_r <= 1'b1;
            wData_r <= '0;
            wStrb_r <= '0;
        end else if (s_axi_wvalid && wready_r) begin
            wready_r <= 1'b0;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
        end else if (bvalid_r && s_axi_bready) begin
            wready_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= rwo_pkg::RESP_OKAY;
        end else if (wrExec) begin
            bvalid_r <= 1'b1;
            // a command during the write cycle is the refused address of the link
            if (regSel(awAddr_r) != rwo_pkg::SEL_CMD || busy) begin
                bresp_r <= rwo_pkg::RESP_SLVERR;
            end else begin
                bresp_r <= rwo_pkg::RESP_OKAY;
            end
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // commands do not look at shutdown: they run the same in both modes
    assign cmdGo = wrExec && regSel(awAddr_r) == rwo_pkg::SEL_CMD && !busy;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            frame_r <= rwo_pkg::FRAME_RESET;
        end else if (cmdGo) begin
            frame_r <= frameNew;
        end
    end

    // ---- AXI4-Lite read side
    assign statusWord = {18'h0, otpLastAddr, 4'h0, calibEnable_r, !aSwitchClosed_r,
        !busy, busy};

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= rwo_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= rwo_pkg::RESP_OKAY;
            case (regSel(s_axi_araddr))
                rwo_pkg::SEL_CMD: rdata_r <= {16'h0, frame_r};
                rwo_pkg::SEL_READBACK: rdata_r <= {16'h0, readback_r};
                // after a store the acknowledge in bit 1 here is back once the write cycle ends
                rwo_pkg::SEL_STATUS: rdata_r <= statusWord;
                default: begin
                    rdata_r <= '0;
                    rresp_r <= rwo_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    // ---- reset sequencing and wiper
    assign anyReset = !rstPinN || (cmdGo && frameNew.cmd == rwo_pkg::CMD_SW_RESET);
    assign restoreVal = (otpLastAddr != 6'h00) ? otpLastData : MIDSCALE;
    assign busy = timerBusy || state_r != rwo_pkg::ST_RUN;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r <= rwo_pkg::ST_MIDSCALE;
        end else if (!rstPinN) begin
            state_r <= rwo_pkg::ST_MIDSCALE;
        end else begin
            case (state_r)
                rwo_pkg::ST_MIDSCALE: state_r <= rwo_pkg::ST_RESTORE;
                rwo_pkg::ST_RESTORE: state_r <= rwo_pkg::ST_RUN;
                rwo_pkg::ST_RUN: begin
                    if (anyReset) begin
                        state_r <= rwo_pkg::ST_RESTORE;
                    end
                end
                default: state_r <= rwo_pkg::ST_MIDSCALE;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wiper_r <= MIDSCALE;
        end else if (state_r == rwo_pkg::ST_MIDSCALE) begin
            wiper_r <= MIDSCALE;
        end else if (state_r == rwo_pkg::ST_RESTORE) begin
            wiper_r <= restoreVal;
        end else if (cmdGo && frameNew.cmd == rwo_pkg::CMD_WR_WIPER && ctrl_r.updAllow) begin
            wiper_r <= frameNew.data[rwo_pkg::FRAME_DATA_W-1 -: WIPER_W];
        end
    end

    // ---- control bits
    assign storeGo = cmdGo && frameNew.cmd == rwo_pkg::CMD_STORE;
    assign storeOk = storeGo && ctrl_r.progEn && !otpFull;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= rwo_pkg::CTRL_RESET;
        end else if (anyReset) begin
            ctrl_r <= rwo_pkg::CTRL_RESET;
        end else if (cmdGo && frameNew.cmd == rwo_pkg::CMD_WR_CTRL) begin
            ctrl_r.progEn <= frameNew.data[0];
            ctrl_r.updAllow <= frameNew.data[1];
            ctrl_r.calibDis <= frameNew.data[2];
        end else if (storeGo) begin
            ctrl_r.success <= storeOk;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            calibEnable_r <= 1'b1;
        end else begin
            calibEnable_r <= !ctrl_r.calibDis;
        end
    end

    // switch state is the inverse of shutdown, so shutdown needs no flop of its own
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            aSwitchClosed_r <= 1'b1;
        end else if (anyReset) begin
            aSwitchClosed_r <= 1'b1;
        end else if (cmdGo && frameNew.cmd == rwo_pkg::CMD_SHUTDOWN) begin
            aSwitchClosed_r <= !frameNew.data[0];
        end
    end

    // ---- readback word for the next frame
    assign wiperWord = toWord(wiper_r);
    assign otpWord = toWord(otpRdData);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            readback_r <= '0;
        end else if (cmdGo) begin
            case (frameNew.cmd)
                rwo_pkg::CMD_RD_WIPER: readback_r <= {6'h00, wiperWord};
                rwo_pkg::CMD_RD_OTP: readback_r <= {6'h00, otpWord};
                rwo_pkg::CMD_RD_LAST: readback_r <= {10'h000, otpLastAddr};
                rwo_pkg::CMD_RD_CTRL: readback_r <= {12'h000, ctrl_r};
                default: readback_r <= frameNew;
            endcase
        end
    end

    // ---- tap decode: one-hot select of the resistor string
    genvar gi;
    generate
        for (gi = 0; gi < TAPS; gi++) begin : g_tap
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    tapSelect_r[gi] <= 1'(gi == TAPS / 2);
                end else begin
                    tapSelect_r[gi] <= (wiper_r == WIPER_W'(gi));
                end
            end
        end
    endgenerate

    rwo_otp_mem #(
        .WIPER_W(WIPER_W),
        .DEPTH(rwo_pkg::OTP_DEPTH)
    ) u_otp (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .wrEn(storeOk),
        .wrData(wiper_r),
        .rdAddr(frameNew.data[5:0]),
        .rdData(otpRdData),
        .lastData(otpLastData),
        .lastAddr(otpLastAddr),
        .full(otpFull)
    );

    rwo_write_timer #(
        .CYC_PER_US(rwo_pkg::CYC_PER_US),
        .WRITE_US(OTP_WRITE_US)
    ) u_timer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .start(storeOk),
        .busy(timerBusy)
    );

    busy_refuse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        wrExec && busy |=> bvalid_r && bresp_r == rwo_pkg::RESP_SLVERR && $stable(frame_r))
        else $error("command taken during write cycle");
    poll_ack_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        s_axi_arvalid && arready_r && s_axi_araddr == rwo_pkg::ADDR_STATUS
        |=> rdata_r[rwo_pkg::STS_ACK] == !$past(busy)) else $error("poll ack wrong");
    swreset_load_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        cmdGo && frameNew.cmd == rwo_pkg::CMD_SW_RESET && rstPinN
        |=> state_r == rwo_pkg::ST_RESTORE ##1 wiper_r == $past(restoreVal))
        else $error("reset did not restore wiper");
    poweron_mid_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == rwo_pkg::ST_MIDSCALE && rstPinN
        |=> wiper_r == MIDSCALE && state_r == rwo_pkg::ST_RESTORE ##1 state_r == rwo_pkg::ST_RUN)
        else $error("power-on preset sequence wrong");
    wiper_frozen_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == rwo_pkg::ST_RUN && !ctrl_r.updAllow |=> $stable(wiper_r))
        else $error("wiper moved while frozen");
    store_gate_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        storeGo && (!ctrl_r.progEn || otpFull) && rstPinN
        |=> !ctrl_r.success && $stable(otpLastAddr) && !timerBusy)
        else $error("refused store changed memory");
    store_ok_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        storeOk && rstPinN |=> ctrl_r.success && timerBusy && otpLastAddr == $past(otpLastAddr) + 6'h01)
        else $error("store did not program");
    shutdown_cmd_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        cmdGo && frameNew.cmd == rwo_pkg::CMD_SHUTDOWN && rstPinN
        |=> aSwitchClosed_r == !$past(frameNew.data[0])) else $error("shutdown not applied");
    calib_bit_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        cmdGo && frameNew.cmd == rwo_pkg::CMD_WR_CTRL && rstPinN
        |=> ##1 calibEnable_r == !$past(frameNew.data[2], 2)) else $error("calibration bit lost");
    tap_onehot_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        state_r == rwo_pkg::ST_RUN |=> $onehot(tapSelect_r) && tapSelect_r[$past(wiper_r)])
        else $error("tap decode wrong");
    otp_read_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        cmdGo && frameNew.cmd == rwo_pkg::CMD_RD_OTP |=> readback_r == {6'h00, $past(otpWord)})
        else $error("memory readback wrong");
endmodule // rwo_wiper_ctrl

// file: tb/rwo_host_model.sv
// rwo_host_model: AXI4-Lite host that issues command frames to the wiper block
// assumes one clock; ready lines sampled at rising edges, bready and rready held high
`timescale 1ns/100ps
module rwo_host_model (
    input wire logic clk_sys,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_araddr, s_axi_arvalid} = '0;
        s_axi_wstrb = 4'hf;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
    endtask
    // refused no-op frames stand for the unacknowledged address; bounded retries
    task automatic poll();
        logic [1:0] r;
        int n;
        n = 0;
        do begin
            wr(8'h00, 32'h0, r);
            n++;
        end while (r !== 2'b00 && n < 300);
        // one idle edge, so a note pushed next is never matched to the last poll answer
        @(posedge clk_sys);
    endtask
endmodule // rwo_host_model

// file: tb/rwo_wiper_otp_control_bench.sv
// rwo_wiper_otp_control_bench: command scenarios against the wiper block
// assumes the host model above; write cycle shortened to 100 cycles
`timescale 1ns/100ps
module rwo_wiper_otp_control_bench;
    localparam logic [1:0] OK = rwo_pkg::RESP_OKAY;
    localparam logic [1:0] ER = rwo_pkg::RESP_SLVERR;
    logic clk_sys = 0, resetn = 0, rstPinN = 0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, xs = 51, rdv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, aSwitchClosed, calibEnable;
    logic [9:0] wiperCode, v;
    logic [1023:0] tapSelect;
    logic [33:0] notes[$];
    int n_mismatch = 0, total_checks = 0;
    always #10 clk_sys = ~clk_sys;
    rwo_host_model host(.clk_sys, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
        .s_axi_rready);
    rwo_wiper_ctrl #(.OTP_WRITE_US(2)) DUT(.clk_sys, .resetn, .rstPinN, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .wiperCode, .tapSelect, .aSwitchClosed, .calibEnable);
    function automatic logic [31:0] rnd();
        xs ^= xs << 13;
        xs ^= xs >> 17;
        xs ^= xs << 5;
        return xs;
    endfunction
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // responses are judged in arrival order; polling traffic leaves no note
    always @(posedge clk_sys) begin
        if (s_axi_bvalid && s_axi_bready && notes.size() > 0)
            check({s_axi_bresp, 32'h0}, notes.pop_front());
        if (s_axi_rvalid && s_axi_rready && notes.size() > 0)
            check({s_axi_rresp, s_axi_rdata}, notes.pop_front());
    end
    task automatic wcmd(input logic [3:0] c, input logic [9:0] d, input logic [1:0] e);
        notes.push_back({e, 32'h0});
        host.wr(rwo_pkg::ADDR_CMD, {18'h0, c, d}, r);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [33:0] e);
        notes.push_back(e);
        host.rd(a, rdv);
    endtask
    task automatic res(input logic [3:0] c, input logic [9:0] d, input logic [31:0] e);
        wcmd(c, d, OK);
        rchk(rwo_pkg::ADDR_READBACK, {OK, e});
    endtask
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1;
        rstPinN <= 1;
        repeat (3) @(posedge clk_sys);
        rchk(rwo_pkg::ADDR_STATUS, {OK, 32'h0000000a});
        res(4'h2, 0, 32'h200);
        wcmd(4'h1, 10'h155, OK);
        res(4'h2, 0, 32'h200);
        wcmd(4'h7, 10'h3, OK);
        v = 10'(rnd());
        wcmd(4'h1, v, OK);
        res(4'h2, 0, {22'h0, v});
        check({33'h0, $countones(tapSelect) == 1 && tapSelect[v]}, 34'h1);
        check({24'h0, wiperCode}, {24'h0, v});
        wcmd(4'h3, 0, OK);
        wcmd(4'h0, 0, ER);
        rchk(rwo_pkg::ADDR_STATUS, {OK, 32'h00000109});
        host.poll();
        rchk(rwo_pkg::ADDR_STATUS, {OK, 32'h0000010a});
        res(4'h8, 0, 32'hb);
        res(4'h6, 0, 32'h1);
        res(4'h5, 10'h3c1, {22'h0, v});
        res(4'h5, 10'h000, 32'h0);
        wcmd(4'h1, 10'h0aa, OK);
        wcmd(4'h4, 0, OK);
        res(4'h2, 0, {22'h0, v});
        wcmd(4'h9, 10'h1, OK);
        step();
        check({33'h0, aSwitchClosed}, 34'h0);
        res(4'h2, 0, {22'h0, v});
        wcmd(4'h9, 10'h0, OK);
        step();
        check({33'h0, aSwitchClosed}, 34'h1);
        wcmd(4'h7, 10'h4, OK);
        step();
        check({33'h0, calibEnable}, 34'h0);
        wcmd(4'h3, 0, OK);
        wcmd(4'h0, 0, OK);
        res(4'h8, 0, 32'h4);
        res(4'h6, 0, 32'h1);
        wcmd(4'h7, 10'h6, OK);
        wcmd(4'h1, 10'h011, OK);
        wcmd(4'h9, 10'h1, OK);
        @(posedge clk_sys);
        rstPinN <= 0;
        repeat (3) @(posedge clk_sys);
        rstPinN <= 1;
        repeat (3) @(posedge clk_sys);
        res(4'h2, 0, {22'h0, v});
        check({33'h0, calibEnable}, 34'h1);
        check({33'h0, aSwitchClosed}, 34'h1);
        rchk(8'h0c, {ER, 32'h0});
        complete_run();
    end
endmodule // rwo_wiper_otp_control_bench
